// >>> hdl/usb_irq_pkg.sv
// constants shared by the usb interrupt flag logic
package usb_irq_pkg;
	// register byte addresses on the wishbone bus
	localparam logic [5:0] host_flags_addr = 6'h00;
	localparam logic [5:0] event_enables_addr = 6'h04;
	localparam logic [5:0] error_flags_addr = 6'h08;
	localparam logic [5:0] error_enables_addr = 6'h0c;
	localparam logic [5:0] stat_queue_addr = 6'h10;
	// main flag bit positions
	localparam int stall_bit = 7;
	localparam int attach_bit = 6;
	localparam int resume_bit = 5;
	localparam int idle_bit = 4;
	localparam int token_bit = 3;
	localparam int sof_bit = 2;
	localparam int err_sum_bit = 1;
	localparam int detach_bit = 0;
	// error flag bit positions
	localparam int stuff_bit = 7;
	localparam int overrun_bit = 5;
	localparam int turnaround_bit = 4;
	localparam int bytemul_bit = 3;
	localparam int crc16_bit = 2;
	localparam int crc5_eof_bit = 1;
	localparam int pid_bit = 0;
	// implemented bits and reset values
	localparam logic [7:0] main_impl_mask = 8'hff;
	localparam logic [7:0] err_impl_mask = 8'hbf;
	localparam logic [7:0] device_enable_mask = 8'hbe;
	localparam logic [7:0] flags_reset = 8'h00;
	localparam logic [7:0] enables_reset = 8'h00;
	// device mode: attach enable inactive, bit 0 kept as bus reset enable
	localparam logic [7:0] device_gate_mask = 8'hbf;
	// timing
	localparam int clk_mhz = 200;
	localparam int k_state_ns = 2500;
	localparam int attach_quiet_ns = 2500;
	localparam int idle_ms = 3;
	localparam int k_state_cycles = (k_state_ns * clk_mhz + 999) / 1000;
	localparam int attach_cycles = (attach_quiet_ns * clk_mhz + 999) / 1000;
	localparam int idle_cycles = idle_ms * 1000 * clk_mhz;
endpackage

// >>> hdl/line_timer.sv
// counts how long a line condition has stood and pulses once when it reaches the limit
`timescale 1ns/1ps
module line_timer #(
	parameter int limit = 500,
	parameter int width = 24
) (
	input wire logic clk_i, // system clock
	input wire logic rst_i, // synchronous reset
	input wire logic cond_i, // condition being timed
	output logic hit_o // one pulse when limit reached
);
	logic [width-1:0] cnt_r;
	// count while condition holds, pulse exactly at the limit
	always_ff @(posedge clk_i) begin
		if (rst_i || !cond_i) begin
			cnt_r <= '0;
			hit_o <= 1'b0;
		end else begin
			hit_o <= (cnt_r == width'(limit - 1));
			if (cnt_r != width'(limit))
				cnt_r <= cnt_r + 1'b1;
		end
	end
endmodule

// >>> hdl/status_fifo.sv
// small transaction status queue, advanced by clearing token done
`timescale 1ns/1ps
module status_fifo #(
	parameter int width = 8,
	parameter int depth = 4
) (
	input wire logic clk_i, // system clock
	input wire logic rst_i, // synchronous reset
	input wire logic push_i, // new token status
	input wire logic [width-1:0] data_i, // status word
	input wire logic pop_i, // advance to next entry
	output logic [width-1:0] head_o, // registered head entry
	output logic empty_o, // no entry queued
	output logic full_o // queue full, push dropped
);
	localparam int aw = $clog2(depth);
	logic [width-1:0] mem_r [depth];
	logic [aw-1:0] wp_r;
	logic [aw-1:0] rp_r;
	logic [aw:0] cnt_r;
	logic do_push;
	logic do_pop;
	assign empty_o = (cnt_r == '0);
	assign full_o = (cnt_r == (aw+1)'(depth));
	assign do_push = push_i && !full_o;
	assign do_pop = pop_i && !empty_o;
	// storage and pointers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			if (do_push) begin
				mem_r[wp_r] <= data_i;
				wp_r <= wp_r + 1'b1;
			end
			if (do_pop)
				rp_r <= rp_r + 1'b1;
			cnt_r <= cnt_r + (aw+1)'(do_push) - (aw+1)'(do_pop);
		end
	end
	// head word comes out of a register
	always_ff @(posedge clk_i) begin
		if (rst_i)
			head_o <= '0;
		else if (do_pop)
			head_o <= (cnt_r > (aw+1)'(1)) ? mem_r[rp_r + 1'b1] : '0;
		else if (cnt_r == '0 && do_push)
			head_o <= data_i;
		else if (!empty_o)
			head_o <= mem_r[rp_r];
	end
endmodule

// >>> hdl/usb_interrupt_flag_logic.sv
// usb interrupt status, enable and error flag registers with wishbone access
// Functional notes
// - flags clear only on a written one; whole-word writes clear every set one except the read-only error summary
// - upper byte of all four registers reads zero
// - all flags and enables are zero after reset; flags are hardware set
// - stall flag sets when a stall handshake is sent
// - host attach flag sets after 2.5 us non-SE0 with no bus activity
// - resume flag sets after k-state held 2.5 us; k depends on speed
// - idle flag sets after 3 ms constant idle
// - token done flag sets when token processing completes; status queued
// - clearing token done advances the transaction status queue
// - frame start flag sets on sof token or host sof threshold
// - error summary sets only from an enabled error flag
// - host detach flag sets on detach, re-arms only after bus reset clears
// - enables gate matching flags; bit 0 is bus reset or detach by mode (flag bit 0 only sets on host-mode detach, never on bus reset)
// - in device mode attach and detach enables read zero
// - stuffing error flag sets on bit stuffing violation
// - overrun flag sets when bytes exceed descriptor count; data truncated
// - turnaround timeout flag sets on bus turnaround timeout
// - byte multiple error sets on non-integral data field
// - data crc error sets on failed 16-bit crc
// - device mode error bit 1 flags token crc5 rejection
// - host mode error bit 1 flags end-of-frame error
// - packet id error sets on failed pid check
// - error enables gate matching error flags; bit 1 by mode
//
// Design decisions made here: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
module usb_interrupt_flag_logic #(
	parameter int idle_limit = usb_irq_pkg::idle_cycles,
	parameter int fifo_depth = 4
) (
	input wire logic clk_i, // system clock
	input wire logic rst_i, // synchronous reset, active high
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // wishbone write
	input wire logic [3:0] wb_sel_i, // wishbone byte selects
	input wire logic [5:0] wb_adr_i, // wishbone byte address
	input wire logic [31:0] wb_dat_i, // wishbone write data
	output logic [31:0] wb_dat_o, // wishbone read data
	output logic wb_ack_o, // wishbone acknowledge
	input wire logic host_mode_i, // 1 = host, 0 = device
	input wire logic low_speed_i, // 1 = low speed link
	input wire logic se0_i, // line is se0
	input wire logic diff_one_i, // line differential one
	input wire logic bus_active_i, // any bus activity
	input wire logic line_idle_i, // line in idle state
	input wire logic stall_sent_i, // stall handshake sent
	input wire logic token_done_i, // token processing complete
	input wire logic [7:0] token_stat_i, // endpoint info for token
	input wire logic sof_event_i, // sof received or threshold
	input wire logic detach_i, // peripheral detach seen
	input wire logic bus_reset_i, // bus reset state present
	input wire logic stuff_err_i, // bit stuff violation
	input wire logic overrun_err_i, // more bytes than byte count
	input wire logic turnaround_err_i, // turnaround timeout
	input wire logic bytemul_err_i, // non-integral data field
	input wire logic crc16_err_i, // data crc failed
	input wire logic crc5_err_i, // token crc5 failed (device)
	input wire logic eof_err_i, // end-of-frame error (host)
	input wire logic pid_err_i, // pid check failed
	output logic [7:0] stat_head_o, // head of transaction status queue
	output logic stat_valid_o, // queue holds an entry
	output logic truncate_o, // received data cut at byte count
	output logic irq_o // module interrupt request
);
	logic [7:0] host_flags_r;
	logic [7:0] event_enables_r;
	logic [7:0] error_flags_r;
	logic [7:0] error_enables_r;
	logic [7:0] main_set;
	logic [7:0] err_set;
	logic [7:0] main_clr;
	logic [7:0] err_clr;
	logic [7:0] en_view;
	logic detach_armed_r;
	logic k_state;
	logic resume_hit;
	logic attach_hit;
	logic idle_hit;
	logic stat_empty;
	logic wr_acc;
	logic low_lane;

	// one-pulse-per-interval line timers
	line_timer #(.limit(usb_irq_pkg::k_state_cycles), .width(24)) u_resume (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cond_i(k_state),
		.hit_o(resume_hit)
	);
	line_timer #(.limit(usb_irq_pkg::attach_cycles), .width(24)) u_attach (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cond_i(host_mode_i && !se0_i && !bus_active_i),
		.hit_o(attach_hit)
	);
	line_timer #(.limit(idle_limit), .width(24)) u_idle (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cond_i(line_idle_i),
		.hit_o(idle_hit)
	);

	// status queue for token endpoint information
	status_fifo #(.width(8), .depth(fifo_depth)) u_stat (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.push_i(token_done_i),
		.data_i(token_stat_i),
		.pop_i(main_clr[usb_irq_pkg::token_bit] && host_flags_r[usb_irq_pkg::token_bit]),
		.head_o(stat_head_o),
		.empty_o(stat_empty),
		.full_o()
	);
	assign stat_valid_o = !stat_empty;
	assign truncate_o = overrun_err_i;

	// k-state polarity follows link speed
	assign k_state = low_speed_i ? diff_one_i : (!diff_one_i && !se0_i);

	// write decode: a write lands at the acknowledged edge, low byte lane selected
	assign wr_acc = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
	assign low_lane = wb_sel_i[0];
	assign main_clr = (wr_acc && low_lane && wb_adr_i == usb_irq_pkg::host_flags_addr)
		? wb_dat_i[7:0] : 8'h00;
	assign err_clr = (wr_acc && low_lane && wb_adr_i == usb_irq_pkg::error_flags_addr)
		? wb_dat_i[7:0] : 8'h00;

	// hardware error events; bit 1 source chosen by mode
	always_comb begin
		err_set = 8'h00;
		err_set[usb_irq_pkg::stuff_bit] = stuff_err_i;
		err_set[usb_irq_pkg::overrun_bit] = overrun_err_i;
		err_set[usb_irq_pkg::turnaround_bit] = turnaround_err_i;
		err_set[usb_irq_pkg::bytemul_bit] = bytemul_err_i;
		err_set[usb_irq_pkg::crc16_bit] = crc16_err_i;
		err_set[usb_irq_pkg::crc5_eof_bit] = host_mode_i ? eof_err_i : crc5_err_i;
		err_set[usb_irq_pkg::pid_bit] = pid_err_i;
	end

	// error flags: set wins over a simultaneous clear
	always_ff @(posedge clk_i) begin
		if (rst_i)
			error_flags_r <= usb_irq_pkg::flags_reset;
		else
			error_flags_r <= ((error_flags_r & ~err_clr) | err_set) & usb_irq_pkg::err_impl_mask;
	end

	// main flag events
	always_comb begin
		main_set = 8'h00;
		main_set[usb_irq_pkg::stall_bit] = stall_sent_i;
		main_set[usb_irq_pkg::attach_bit] = attach_hit;
		main_set[usb_irq_pkg::resume_bit] = resume_hit;
		main_set[usb_irq_pkg::idle_bit] = idle_hit;
		main_set[usb_irq_pkg::token_bit] = token_done_i;
		main_set[usb_irq_pkg::sof_bit] = sof_event_i;
		main_set[usb_irq_pkg::err_sum_bit] = |(error_flags_r & error_enables_r);
		main_set[usb_irq_pkg::detach_bit] = host_mode_i && detach_i && detach_armed_r;
	end

	// detach re-arms only once the bus reset state has gone
	always_ff @(posedge clk_i) begin
		if (rst_i)
			detach_armed_r <= 1'b1;
		else if (main_set[usb_irq_pkg::detach_bit])
			detach_armed_r <= 1'b0;
		else if (!bus_reset_i)
			detach_armed_r <= 1'b1;
	end

	// main flags: summary bit is read-only and tracks enabled errors
	always_ff @(posedge clk_i) begin
		if (rst_i)
			host_flags_r <= usb_irq_pkg::flags_reset;
		else begin
			host_flags_r <= (host_flags_r & ~main_clr) | main_set;
			host_flags_r[usb_irq_pkg::err_sum_bit] <= main_set[usb_irq_pkg::err_sum_bit];
		end
	end

	// enable registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			event_enables_r <= usb_irq_pkg::enables_reset;
			error_enables_r <= usb_irq_pkg::enables_reset;
		end else if (wr_acc && low_lane) begin
			if (wb_adr_i == usb_irq_pkg::event_enables_addr)
				event_enables_r <= wb_dat_i[7:0];
			if (wb_adr_i == usb_irq_pkg::error_enables_addr)
				error_enables_r <= wb_dat_i[7:0] & usb_irq_pkg::err_impl_mask;
		end
	end

	// device mode hides the attach and detach enables
	assign en_view = host_mode_i ? event_enables_r : (event_enables_r & usb_irq_pkg::device_enable_mask);
	// bit 0 in device mode is the bus reset enable and stays usable
	logic [7:0] en_gate;
	assign en_gate = host_mode_i ? event_enables_r : (event_enables_r & usb_irq_pkg::device_gate_mask);

	// interrupt request from enabled main flags
	always_ff @(posedge clk_i) begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(host_flags_r & en_gate);
	end

	// wishbone acknowledge and read data
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			unique case (wb_adr_i)
				usb_irq_pkg::host_flags_addr: wb_dat_o <= {24'h000000, host_flags_r};
				usb_irq_pkg::event_enables_addr: wb_dat_o <= {24'h000000, en_view};
				usb_irq_pkg::error_flags_addr: wb_dat_o <= {24'h000000, error_flags_r};
				usb_irq_pkg::error_enables_addr: wb_dat_o <= {24'h000000, error_enables_r};
				usb_irq_pkg::stat_queue_addr: wb_dat_o <= {23'h0, stat_valid_o, stat_head_o};
				default: wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// checks
	property p_clear_one;
		@(posedge clk_i) disable iff (rst_i)
		(main_clr[usb_irq_pkg::stall_bit] && !stall_sent_i) |=> !host_flags_r[usb_irq_pkg::stall_bit];
	endproperty
	a_clear_one: assert property (p_clear_one) else $error("stall flag not cleared");
	property p_upper_zero;
		@(posedge clk_i) disable iff (rst_i) wb_ack_o |-> wb_dat_o[31:9] == 23'h0;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper bits not zero");
	property p_set_wins;
		@(posedge clk_i) disable iff (rst_i) err_set[usb_irq_pkg::pid_bit] |=> error_flags_r[usb_irq_pkg::pid_bit];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("pid flag lost");
	property p_stall;
		@(posedge clk_i) disable iff (rst_i) stall_sent_i |=> host_flags_r[usb_irq_pkg::stall_bit];
	endproperty
	a_stall: assert property (p_stall) else $error("stall flag missing");
	property p_summary;
		@(posedge clk_i) disable iff (rst_i)
		host_flags_r[usb_irq_pkg::err_sum_bit] |-> $past(|(error_flags_r & error_enables_r));
	endproperty
	a_summary: assert property (p_summary) else $error("summary without enabled error");
	property p_irq;
		@(posedge clk_i) disable iff (rst_i) |(host_flags_r & en_gate) |=> irq_o;
	endproperty
	a_irq: assert property (p_irq) else $error("irq missing");
	property p_dev_mask;
		@(posedge clk_i) disable iff (rst_i) (!host_mode_i) |-> en_view[usb_irq_pkg::attach_bit] == 1'b0;
	endproperty
	a_dev_mask: assert property (p_dev_mask) else $error("attach enable visible");
	property p_eof;
		@(posedge clk_i) disable iff (rst_i)
		(host_mode_i && eof_err_i) |=> error_flags_r[usb_irq_pkg::crc5_eof_bit];
	endproperty
	a_eof: assert property (p_eof) else $error("eof flag missing");
	property p_ack_one;
		@(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack held");
	// clearing and reset
	property p_clear_err;
		@(posedge clk_i) disable iff (rst_i)
		(err_clr[usb_irq_pkg::stuff_bit] && !stuff_err_i) |=> !error_flags_r[usb_irq_pkg::stuff_bit];
	endproperty
	a_clear_err: assert property (p_clear_err) else $error("stuffing flag not cleared");
	property p_reset_vals;
		@(posedge clk_i) rst_i |=> (host_flags_r | error_flags_r | event_enables_r | error_enables_r) == 8'h00 && !irq_o;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("register not zero after reset");
	// main events land in their flags one cycle later; also attach host-only, summary clear, detach block and irq gating
	property p_attach;
		@(posedge clk_i) disable iff (rst_i) attach_hit |=> host_flags_r[usb_irq_pkg::attach_bit];
	endproperty
	a_attach: assert property (p_attach) else $error("attach flag missing");
	property p_attach_host;
		@(posedge clk_i) disable iff (rst_i) attach_hit |-> $past(host_mode_i);
	endproperty
	a_attach_host: assert property (p_attach_host) else $error("attach seen outside host mode");
	property p_resume;
		@(posedge clk_i) disable iff (rst_i) resume_hit |=> host_flags_r[usb_irq_pkg::resume_bit];
	endproperty
	a_resume: assert property (p_resume) else $error("resume flag missing");
	property p_idle;
		@(posedge clk_i) disable iff (rst_i) idle_hit |=> host_flags_r[usb_irq_pkg::idle_bit];
	endproperty
	a_idle: assert property (p_idle) else $error("idle flag missing");
	property p_token;
		@(posedge clk_i) disable iff (rst_i) token_done_i |=> host_flags_r[usb_irq_pkg::token_bit];
	endproperty
	a_token: assert property (p_token) else $error("token done flag missing");
	property p_sof;
		@(posedge clk_i) disable iff (rst_i) sof_event_i |=> host_flags_r[usb_irq_pkg::sof_bit];
	endproperty
	a_sof: assert property (p_sof) else $error("frame start flag missing");
	property p_sum_set;
		@(posedge clk_i) disable iff (rst_i) |(error_flags_r & error_enables_r) |=> host_flags_r[usb_irq_pkg::err_sum_bit];
	endproperty
	a_sum_set: assert property (p_sum_set) else $error("summary missing");
	property p_no_sum;
		@(posedge clk_i) disable iff (rst_i) !(|(error_flags_r & error_enables_r)) |=> !host_flags_r[usb_irq_pkg::err_sum_bit];
	endproperty
	a_no_sum: assert property (p_no_sum) else $error("summary without cause");
	property p_detach_block;
		@(posedge clk_i) disable iff (rst_i)
		(bus_reset_i && !detach_armed_r && !host_flags_r[usb_irq_pkg::detach_bit]) |=> !host_flags_r[usb_irq_pkg::detach_bit];
	endproperty
	a_detach_block: assert property (p_detach_block) else $error("detach reasserted in bus reset");
	property p_gate_off;
		@(posedge clk_i) disable iff (rst_i) !(|(host_flags_r & en_gate)) |=> !irq_o;
	endproperty
	a_gate_off: assert property (p_gate_off) else $error("irq without enabled flag");
	// each error event lands in its flag one cycle later
	property p_stuff;
		@(posedge clk_i) disable iff (rst_i) stuff_err_i |=> error_flags_r[usb_irq_pkg::stuff_bit];
	endproperty
	a_stuff: assert property (p_stuff) else $error("stuffing flag missing");
	property p_overrun;
		@(posedge clk_i) disable iff (rst_i) overrun_err_i |=> error_flags_r[usb_irq_pkg::overrun_bit];
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun flag missing");
	property p_turnaround;
		@(posedge clk_i) disable iff (rst_i) turnaround_err_i |=> error_flags_r[usb_irq_pkg::turnaround_bit];
	endproperty
	a_turnaround: assert property (p_turnaround) else $error("turnaround flag missing");
	property p_bytemul;
		@(posedge clk_i) disable iff (rst_i) bytemul_err_i |=> error_flags_r[usb_irq_pkg::bytemul_bit];
	endproperty
	a_bytemul: assert property (p_bytemul) else $error("byte multiple flag missing");
	property p_crc16;
		@(posedge clk_i) disable iff (rst_i) crc16_err_i |=> error_flags_r[usb_irq_pkg::crc16_bit];
	endproperty
	a_crc16: assert property (p_crc16) else $error("data crc flag missing");
	property p_crc5;
		@(posedge clk_i) disable iff (rst_i) (!host_mode_i && crc5_err_i) |=> error_flags_r[usb_irq_pkg::crc5_eof_bit];
	endproperty
	a_crc5: assert property (p_crc5) else $error("token crc flag missing");
	c_token: cover property (@(posedge clk_i) disable iff (rst_i) token_done_i ##[1:20] main_clr[usb_irq_pkg::token_bit]);
	c_resume: cover property (@(posedge clk_i) disable iff (rst_i) resume_hit);
	c_irq: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
	c_detach_blocked: cover property (@(posedge clk_i) disable iff (rst_i) bus_reset_i && detach_i && !detach_armed_r);
	c_summary: cover property (@(posedge clk_i) disable iff (rst_i) $rose(host_flags_r[usb_irq_pkg::err_sum_bit]));
endmodule

// >>> verif/usb_line_model.sv
// far-side usb line and packet engine model driving events and line levels
`timescale 1ns/1ps
module usb_line_model (
	input wire logic clk_i, // system clock
	input wire logic [11:0] ev_req_i, // event requests from the bench
	input wire logic [1:0] line_mode_i, // 0 traffic, 1 k, 2 idle j, 3 se0
	input wire logic low_speed_i, // link speed
	output logic [11:0] ev_o, // one-cycle event pulses
	output logic se0_o, // line in se0
	output logic diff_one_o, // differential one on the pair
	output logic bus_active_o, // traffic present
	output logic line_idle_o // idle j state
);
	logic tog_r = 1'b0;
	// events last one cycle; traffic keeps the pair moving
	always_ff @(posedge clk_i) begin
		ev_o <= ev_req_i;
		tog_r <= ~tog_r;
	end
	// line levels; k polarity swaps with speed
	always_comb begin
		se0_o = (line_mode_i == 2'd3);
		bus_active_o = (line_mode_i == 2'd0);
		line_idle_o = (line_mode_i == 2'd2);
		case (line_mode_i)
			2'd1: diff_one_o = low_speed_i;
			2'd2: diff_one_o = ~low_speed_i; // j is the inverse of k
			default: diff_one_o = tog_r; // traffic or se0: no stable level
		endcase
	end
endmodule

// >>> verif/test_usb_interrupt_flag_logic.sv
// self-checking bench for the usb interrupt flag logic
`timescale 1ns/1ps
module test_usb_interrupt_flag_logic;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [3:0] wb_sel_i = 4'h0, sel = 4'hf;
	logic [5:0] wb_adr_i = 6'h00;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
	logic wb_ack_o, irq_o, stat_valid_o, truncate_o, se0, diff_one, bus_active, line_idle;
	logic host_mode_i = 1'b1, low_speed_i = 1'b0, bus_reset_i = 1'b0;
	logic [7:0] token_stat_i = 8'h00, stat_head_o;
	logic [11:0] ev_req = 12'h000, ev;
	logic [1:0] line_mode = 2'd0;
	logic [5:0] adrs [6] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h14};
	int err_idx [7] = '{4, 5, 6, 7, 8, 10, 11};
	logic [31:0] err_bit [7] = '{32'h80, 32'h20, 32'h10, 32'h08, 32'h04, 32'h02, 32'h01};
	int err_count = 0, n_compared = 0, cyc_count = 0;

	initial forever #2.5 clk_i = ~clk_i;

	usb_interrupt_flag_logic #(.idle_limit(50), .fifo_depth(4)) dut_u (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .host_mode_i(host_mode_i), .low_speed_i(low_speed_i), .se0_i(se0),
		.diff_one_i(diff_one), .bus_active_i(bus_active), .line_idle_i(line_idle),
		.stall_sent_i(ev[0]), .token_done_i(ev[1]), .token_stat_i(token_stat_i), .sof_event_i(ev[2]),
		.detach_i(ev[3]), .bus_reset_i(bus_reset_i), .stuff_err_i(ev[4]), .overrun_err_i(ev[5]),
		.turnaround_err_i(ev[6]), .bytemul_err_i(ev[7]), .crc16_err_i(ev[8]), .crc5_err_i(ev[9]),
		.eof_err_i(ev[10]), .pid_err_i(ev[11]), .stat_head_o(stat_head_o), .stat_valid_o(stat_valid_o),
		.truncate_o(truncate_o), .irq_o(irq_o));

	usb_line_model line_u (.clk_i(clk_i), .ev_req_i(ev_req), .line_mode_i(line_mode),
		.low_speed_i(low_speed_i), .ev_o(ev), .se0_o(se0), .diff_one_o(diff_one),
		.bus_active_o(bus_active), .line_idle_o(line_idle));

	task report_and_stop;
		if (err_count == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// one classic wishbone cycle, entered just after a rising edge; writes land at the ack edge
	task xfer(input logic we, input logic [5:0] a, input logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_sel_i <= sel;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		// second idle edge lets registered outputs follow the write
		repeat (2) @(posedge clk_i);
	endtask

	task rdchk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(rd & m, exp);
	endtask

	// one event pulse from the far side; overrun must show as truncation
	task pulse(input int i);
		ev_req[i] <= 1'b1;
		@(posedge clk_i);
		ev_req <= 12'h000;
		#1 chk({31'h0, truncate_o}, {31'h0, i == 5});
		repeat (3) @(posedge clk_i);
	endtask

	// hang guard
	always @(posedge clk_i) begin
		cyc_count <= cyc_count + 1;
		if (cyc_count == 20000) begin
			err_count++;
			report_and_stop();
		end
	end

	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		foreach (adrs[i]) rdchk(adrs[i], '1, 32'h0);
		// writes without the low lane or to an unmapped word are ignored
		sel = 4'he;
		xfer(1'b1, 6'h04, 32'hffff_ffff);
		sel = 4'hf;
		rdchk(6'h04, '1, 32'h0);
		xfer(1'b1, 6'h14, 32'hffff_ffff);
		rdchk(6'h14, '1, 32'h0);
		xfer(1'b1, 6'h04, 32'hffff_ffff);
		rdchk(6'h04, '1, 32'hff);
		xfer(1'b1, 6'h0c, 32'hffff_ffff);
		rdchk(6'h0c, '1, 32'hbf);
		host_mode_i <= 1'b0;
		rdchk(6'h04, '1, 32'hbe);
		host_mode_i <= 1'b1;
		xfer(1'b1, 6'h00, 32'hff);
		rdchk(6'h00, '1, 32'h0);
		// host events, two tokens queued, detach seen during bus reset
		bus_reset_i <= 1'b1;
		token_stat_i <= 8'h5a;
		pulse(1);
		token_stat_i <= 8'h3c;
		pulse(1);
		pulse(0);
		pulse(2);
		pulse(3);
		rdchk(6'h00, '1, 32'h8d);
		chk({31'h0, irq_o}, 32'h1);
		rdchk(6'h10, '1, 32'h15a);
		xfer(1'b1, 6'h00, 32'h08);
		rdchk(6'h00, '1, 32'h85);
		rdchk(6'h10, '1, 32'h13c);
		chk({23'h0, stat_valid_o, stat_head_o}, 32'h13c);
		xfer(1'b1, 6'h00, 32'h00);
		rdchk(6'h00, '1, 32'h85);
		xfer(1'b1, 6'h00, 32'hff);
		rdchk(6'h00, '1, 32'h0);
		chk({31'h0, irq_o}, 32'h0);
		pulse(3);
		rdchk(6'h00, '1, 32'h0);
		bus_reset_i <= 1'b0;
		pulse(3);
		rdchk(6'h00, '1, 32'h1);
		// enable gating of the request
		xfer(1'b1, 6'h04, 32'h7f);
		pulse(0);
		rdchk(6'h00, '1, 32'h81);
		xfer(1'b1, 6'h04, 32'h7e);
		chk({31'h0, irq_o}, 32'h0);
		xfer(1'b1, 6'h04, 32'h80);
		chk({31'h0, irq_o}, 32'h1);
		xfer(1'b1, 6'h00, 32'hff);
		// each host error flag and the summary
		foreach (err_idx[i]) begin
			pulse(err_idx[i]);
			rdchk(6'h08, '1, err_bit[i]);
			rdchk(6'h00, '1, 32'h02);
			xfer(1'b1, 6'h08, 32'hff);
			rdchk(6'h00, '1, 32'h0);
		end
		pulse(9);
		rdchk(6'h08, '1, 32'h0);
		xfer(1'b1, 6'h0c, 32'h0);
		pulse(8);
		rdchk(6'h08, '1, 32'h04);
		rdchk(6'h00, '1, 32'h0);
		xfer(1'b1, 6'h08, 32'hff);
		host_mode_i <= 1'b0;
		xfer(1'b1, 6'h0c, 32'h02);
		pulse(9);
		rdchk(6'h08, '1, 32'h02);
		rdchk(6'h00, 32'h02, 32'h02);
		xfer(1'b1, 6'h08, 32'hff);
		// line timers: idle and attach in host mode
		host_mode_i <= 1'b1;
		xfer(1'b1, 6'h00, 32'hff);
		line_mode <= 2'd2;
		repeat (60) @(posedge clk_i);
		rdchk(6'h00, 32'h50, 32'h10);
		repeat (460) @(posedge clk_i);
		rdchk(6'h00, 32'h50, 32'h50);
		// resume at both speeds, a short k first
		for (int s = 0; s < 2; s++) begin
			line_mode <= 2'd0;
			low_speed_i <= s[0];
			xfer(1'b1, 6'h00, 32'hff);
			line_mode <= 2'd1;
			repeat (400) @(posedge clk_i);
			line_mode <= 2'd0;
			rdchk(6'h00, 32'h20, 32'h0);
			line_mode <= 2'd1;
			repeat (520) @(posedge clk_i);
			rdchk(6'h00, 32'h20, 32'h20);
		end
		report_and_stop();
	end
endmodule
